/* rtl/ssp_buf2.sv */
`timescale 1ns/1ps
module ssp_buf2 #(
	parameter int W     = 16,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} ssp_buf_type;

	ssp_buf_type s_q;
	ssp_buf_type s_d;
	logic        wr;
	logic        rd;

	// honest full and empty from the fill count
	assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = s_q.mem[s_q.rp];
	assign wr        = in_valid & in_ready;
	assign rd        = out_valid & out_ready;

	// ------------------------------------------------------------
	// pointer and count update
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (wr) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp          = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
		end
		if (rd) begin
			s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : ssp_buf2

/* rtl/ssp_pin_sync.sv */
`timescale 1ns/1ps
module ssp_pin_sync #(
	parameter int N = 6
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// raw pins and synchronised views
	input  wire logic [N-1:0] pin_raw,
	output logic      [N-1:0] pin_lvl,
	output logic      [N-1:0] pin_rise,
	output logic      [N-1:0] pin_fall
);

	typedef struct packed {
		logic [N-1:0] meta;
		logic [N-1:0] lvl;
		logic [N-1:0] prev;
	} ssp_sync_type;

	ssp_sync_type s_q;
	ssp_sync_type s_d;

	// ------------------------------------------------------------
	// two-flop synchroniser plus history for edges
	// ------------------------------------------------------------
	always_comb begin
		s_d      = s_q;
		s_d.meta = pin_raw;
		s_d.lvl  = s_q.meta;
		s_d.prev = s_q.lvl;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// edges only look at the second and third flops
	assign pin_lvl  = s_q.lvl;
	assign pin_rise = s_q.lvl & ~s_q.prev;
	assign pin_fall = ~s_q.lvl & s_q.prev;

endmodule : ssp_pin_sync

/* rtl/ssp_pkg.sv */
package ssp_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DIV    = 8'h04;
	localparam logic [7:0] OFS_PCTL   = 8'h08;
	localparam logic [7:0] OFS_PDIR   = 8'h0c;
	localparam logic [7:0] OFS_POUT   = 8'h10;
	localparam logic [7:0] OFS_PIN    = 8'h14;
	localparam logic [7:0] OFS_TXDATA = 8'h18;
	localparam logic [7:0] OFS_RXDATA = 8'h1c;
	localparam logic [7:0] OFS_STATUS = 8'h20;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CTRL_W        = 11;
	localparam int C_TX_EN       = 0;
	localparam int C_RX_EN       = 1;
	localparam int C_ASYNC       = 2;
	localparam int C_CLK_OUT     = 3;
	localparam int C_FS_OUT      = 4;
	localparam int C_RXCLK_OUT   = 5;
	localparam int C_RXFS_OUT    = 6;
	localparam int C_PIN_A_TX    = 7;
	localparam int C_PIN_B_TX    = 8;
	localparam int C_FLAG0       = 9;
	localparam int C_FLAG1       = 10;
	localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

	// ------------------------------------------------------------
	// status register fields
	// ------------------------------------------------------------
	localparam int S_TX_ROOM  = 0;
	localparam int S_RX_VALID = 1;
	localparam int S_TX_URUN  = 2;
	localparam int S_RX_ORUN  = 3;
	localparam int S_TX_BUSY  = 4;

	// ------------------------------------------------------------
	// pin indices and reset values
	// ------------------------------------------------------------
	localparam int PIN_N   = 6;
	localparam int PIN_A   = 0;
	localparam int PIN_B   = 1;
	localparam int PIN_FS  = 2;
	localparam int PIN_SCK = 3;
	localparam int PIN_RXD = 4;
	localparam int PIN_TXD = 5;
	localparam logic [5:0] PORT_RST = 6'h00;

	// ------------------------------------------------------------
	// timing: least system cycles per half serial clock period
	// ------------------------------------------------------------
	localparam logic [7:0] MIN_HALF_CYC = 8'h03;
	localparam logic [7:0] DIV_RST      = 8'h04;
	localparam int         WORD_BITS    = 16;

endpackage : ssp_pkg

/* rtl/ssp_port.sv */
`timescale 1ns/1ps
module ssp_port #(
	parameter int W = ssp_pkg::WORD_BITS
) (
	// system clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// low power state
	input  wire logic        stop_req,
	// control pin a
	input  wire logic        ctrl_pin_a_i,
	output logic             ctrl_pin_a_o,
	output logic             ctrl_pin_a_oe,
	// control pin b
	input  wire logic        ctrl_pin_b_i,
	output logic             ctrl_pin_b_o,
	output logic             ctrl_pin_b_oe,
	// frame sync pin
	input  wire logic        frame_sync_pin_i,
	output logic             frame_sync_pin_o,
	output logic             frame_sync_pin_oe,
	// bit clock pin
	input  wire logic        serial_bit_clock_i,
	output logic             serial_bit_clock_o,
	output logic             serial_bit_clock_oe,
	// receive data pin
	input  wire logic        serial_rx_data_i,
	output logic             serial_rx_data_o,
	output logic             serial_rx_data_oe,
	// transmit data pin
	input  wire logic        serial_tx_data_i,
	output logic             serial_tx_data_o,
	output logic             serial_tx_data_oe
);

	localparam int CW = $clog2(W);
	localparam int PN = ssp_pkg::PIN_N;

	typedef struct packed {
		logic [ssp_pkg::CTRL_W-1:0] ctrl;
		logic [7:0]                 div;
		logic [PN-1:0]              pctl;
		logic [PN-1:0]              pdir;
		logic [PN-1:0]              pout;
		logic [PN-1:0]              pin_o;
		logic [PN-1:0]              pin_oe;
		logic [PN-1:0]              pin_in;
		logic [31:0]                hrdata;
		logic                       hready;
		logic                       hresp;
		logic                       dph_wr;
		logic [7:0]                 dph_addr;
		logic [7:0]                 div_cnt;
		logic                       bclk;
		logic                       fs_int;
		logic [CW-1:0]              frame_cnt;
		logic [W-1:0]               tx_sh;
		logic                       tx_bit;
		logic [CW-1:0]              tx_left;
		logic [W-1:0]               rx_sh;
		logic [CW-1:0]              rx_left;
		logic                       tx_urun;
		logic                       rx_orun;
	} ssp_state_type;

	ssp_state_type s_q;
	ssp_state_type s_d;

	logic [PN-1:0] pin_raw;
	logic [PN-1:0] pin_lvl;
	logic [PN-1:0] pin_rise;
	logic [PN-1:0] pin_fall;
	logic          tx_push;
	logic          tx_room;
	logic          tx_valid;
	logic          tx_pop;
	logic [W-1:0]  tx_word;
	logic          rx_push;
	logic          rx_room;
	logic [W-1:0]  rx_word;
	logic          rx_valid;
	logic          rx_pop;
	logic [W-1:0]  rx_data;

	// ------------------------------------------------------------
	// pin synchroniser and data buffers
	// ------------------------------------------------------------
	assign pin_raw = {serial_tx_data_i, serial_rx_data_i, serial_bit_clock_i,
	                  frame_sync_pin_i, ctrl_pin_b_i, ctrl_pin_a_i};

	ssp_pin_sync #(.N(PN)) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.pin_raw  (pin_raw),
		.pin_lvl  (pin_lvl),
		.pin_rise (pin_rise),
		.pin_fall (pin_fall)
	);

	ssp_buf2 #(.W(W), .DEPTH(2)) u_txbuf (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (tx_push),
		.in_ready  (tx_room),
		.in_data   (hwdata[W-1:0]),
		.out_valid (tx_valid),
		.out_ready (tx_pop),
		.out_data  (tx_word)
	);

	ssp_buf2 #(.W(W), .DEPTH(2)) u_rxbuf (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (rx_push),
		.in_ready  (rx_room),
		.in_data   (rx_word),
		.out_valid (rx_valid),
		.out_ready (rx_pop),
		.out_data  (rx_data)
	);

	// ------------------------------------------------------------
	// next state: bus, bit clock, shifters, pins
	// ------------------------------------------------------------
	always_comb begin
		logic          acc;
		logic          async_m;
		logic [7:0]    half;
		logic          int_rise;
		logic          int_fall;
		logic          b_rise;
		logic          r_fall;
		logic          tx_fs;
		logic          rx_fs;
		logic          tx_start;
		logic [W-1:0]  word;
		logic [PN-1:0] ser_o;
		logic [PN-1:0] ser_oe;
		logic          clr_u;
		logic          clr_o;
		logic          set_u;
		logic          set_o;
		acc      = hsel & htrans[1] & hready;
		async_m  = s_q.ctrl[ssp_pkg::C_ASYNC];
		half     = (s_q.div < ssp_pkg::MIN_HALF_CYC) ? ssp_pkg::MIN_HALF_CYC : s_q.div;
		int_rise = 1'b0;
		int_fall = 1'b0;
		b_rise   = 1'b0;
		r_fall   = 1'b0;
		tx_fs    = 1'b0;
		rx_fs    = 1'b0;
		tx_start = 1'b0;
		word     = '0;
		ser_o    = '0;
		ser_oe   = '0;
		clr_u    = 1'b0;
		clr_o    = 1'b0;
		set_u    = 1'b0;
		set_o    = 1'b0;
		tx_push  = 1'b0;
		tx_pop   = 1'b0;
		rx_push  = 1'b0;
		rx_pop   = 1'b0;
		rx_word  = {s_q.rx_sh[W-2:0], pin_lvl[ssp_pkg::PIN_RXD]};
		s_d      = s_q;
		s_d.hready = 1'b1;
		s_d.hresp  = 1'b0;

		// address phase: latch write, answer reads from registers
		s_d.dph_wr   = acc & hwrite;
		s_d.dph_addr = haddr[7:0];
		s_d.hrdata   = '0;
		if (acc && !hwrite) begin
			unique case (haddr[7:0])
				ssp_pkg::OFS_CTRL:   s_d.hrdata = 32'(s_q.ctrl);
				ssp_pkg::OFS_DIV:    s_d.hrdata = 32'(s_q.div);
				ssp_pkg::OFS_PCTL:   s_d.hrdata = 32'(s_q.pctl);
				ssp_pkg::OFS_PDIR:   s_d.hrdata = 32'(s_q.pdir);
				ssp_pkg::OFS_POUT:   s_d.hrdata = 32'(s_q.pout);
				ssp_pkg::OFS_PIN:    s_d.hrdata = 32'(s_q.pin_in);
				ssp_pkg::OFS_RXDATA: begin
					s_d.hrdata = 32'(rx_data);
					rx_pop     = rx_valid;
				end
				ssp_pkg::OFS_STATUS: begin
					s_d.hrdata[ssp_pkg::S_TX_ROOM]  = tx_room;
					s_d.hrdata[ssp_pkg::S_RX_VALID] = rx_valid;
					s_d.hrdata[ssp_pkg::S_TX_URUN]  = s_q.tx_urun;
					s_d.hrdata[ssp_pkg::S_RX_ORUN]  = s_q.rx_orun;
					s_d.hrdata[ssp_pkg::S_TX_BUSY]  = (s_q.tx_left != '0);
				end
				default:             s_d.hrdata = '0;
			endcase
		end

		// data phase: register writes
		if (s_q.dph_wr) begin
			unique case (s_q.dph_addr)
				ssp_pkg::OFS_CTRL:   s_d.ctrl = hwdata[ssp_pkg::CTRL_W-1:0];
				ssp_pkg::OFS_DIV:    s_d.div  = hwdata[7:0];
				ssp_pkg::OFS_PCTL:   s_d.pctl = hwdata[PN-1:0];
				ssp_pkg::OFS_PDIR:   s_d.pdir = hwdata[PN-1:0];
				ssp_pkg::OFS_POUT:   s_d.pout = hwdata[PN-1:0];
				ssp_pkg::OFS_TXDATA: tx_push  = 1'b1;
				ssp_pkg::OFS_STATUS: begin
					clr_u = hwdata[ssp_pkg::S_TX_URUN];
					clr_o = hwdata[ssp_pkg::S_RX_ORUN];
				end
				default:             ;
			endcase
		end

		// internal bit clock divider, frozen in stop
		if (!stop_req && (s_q.ctrl[ssp_pkg::C_TX_EN] || s_q.ctrl[ssp_pkg::C_RX_EN])) begin
			if (s_q.div_cnt >= half - 8'h01) begin
				s_d.div_cnt = '0;
				s_d.bclk    = ~s_q.bclk;
				int_rise    = ~s_q.bclk;
				int_fall    = s_q.bclk;
			end else begin
				s_d.div_cnt = s_q.div_cnt + 8'h01;
			end
		end

		// pick clock and frame sources; inputs ignored in stop
		b_rise = !stop_req && (s_q.ctrl[ssp_pkg::C_CLK_OUT] ? int_rise : pin_rise[ssp_pkg::PIN_SCK]);
		if (async_m) begin
			r_fall = !stop_req && (s_q.ctrl[ssp_pkg::C_RXCLK_OUT] ? int_fall : pin_fall[ssp_pkg::PIN_A]);
		end else begin
			r_fall = !stop_req && (s_q.ctrl[ssp_pkg::C_CLK_OUT] ? int_fall : pin_fall[ssp_pkg::PIN_SCK]);
		end
		tx_fs = s_q.ctrl[ssp_pkg::C_FS_OUT] ? s_q.fs_int : pin_lvl[ssp_pkg::PIN_FS];
		if (async_m) begin
			rx_fs = s_q.ctrl[ssp_pkg::C_RXFS_OUT] ? s_q.fs_int : pin_lvl[ssp_pkg::PIN_B];
		end else begin
			rx_fs = tx_fs;
		end

		// transmitter on rising bit clock edges
		if (b_rise && (s_q.ctrl[ssp_pkg::C_TX_EN] || s_q.ctrl[ssp_pkg::C_RX_EN])) begin
			s_d.fs_int    = (s_q.frame_cnt == '0);
			s_d.frame_cnt = (s_q.frame_cnt == CW'(W-1)) ? '0 : s_q.frame_cnt + 1'b1;
			tx_start      = s_q.ctrl[ssp_pkg::C_FS_OUT] ? (s_q.frame_cnt == '0) : tx_fs;
		end
		if (b_rise && s_q.ctrl[ssp_pkg::C_TX_EN]) begin
			if (tx_start && s_q.tx_left == '0) begin
				word        = tx_valid ? tx_word : '0;
				tx_pop      = tx_valid;
				set_u       = ~tx_valid;
				s_d.tx_bit  = word[W-1];
				s_d.tx_sh   = {word[W-2:0], 1'b0};
				s_d.tx_left = CW'(W-1);
			end else if (s_q.tx_left != '0) begin
				s_d.tx_bit  = s_q.tx_sh[W-1];
				s_d.tx_sh   = {s_q.tx_sh[W-2:0], 1'b0};
				s_d.tx_left = s_q.tx_left - 1'b1;
			end
		end else if (!s_q.ctrl[ssp_pkg::C_TX_EN]) begin
			s_d.tx_left = '0; // a stopped side drops its half-shifted word
		end

		// receiver on falling edges of its own clock, alongside tx
		if (r_fall && s_q.ctrl[ssp_pkg::C_RX_EN]) begin
			if (s_q.rx_left == '0) begin
				if (rx_fs) begin
					s_d.rx_sh   = rx_word;
					s_d.rx_left = CW'(W-1);
				end
			end else begin
				s_d.rx_sh   = rx_word;
				s_d.rx_left = s_q.rx_left - 1'b1;
				if (s_q.rx_left == CW'(1)) begin
					rx_push = 1'b1;
					set_o   = ~rx_room;
				end
			end
		end else if (!s_q.ctrl[ssp_pkg::C_RX_EN]) begin
			s_d.rx_left = '0; // next word waits for a fresh frame sync
		end

		// sticky errors: a set in the same cycle beats the clear
		s_d.tx_urun = (s_q.tx_urun & ~clr_u) | set_u;
		s_d.rx_orun = (s_q.rx_orun & ~clr_o) | set_o;

		// serial functions of each pin
		if (async_m) begin
			ser_o[ssp_pkg::PIN_A]  = s_q.bclk;
			ser_oe[ssp_pkg::PIN_A] = s_q.ctrl[ssp_pkg::C_RXCLK_OUT];
			ser_o[ssp_pkg::PIN_B]  = s_q.fs_int;
			ser_oe[ssp_pkg::PIN_B] = s_q.ctrl[ssp_pkg::C_RXFS_OUT];
		end else begin
			ser_o[ssp_pkg::PIN_A]  = s_q.ctrl[ssp_pkg::C_PIN_A_TX] ? s_q.tx_bit : s_q.ctrl[ssp_pkg::C_FLAG0];
			ser_oe[ssp_pkg::PIN_A] = 1'b1;
			ser_o[ssp_pkg::PIN_B]  = s_q.ctrl[ssp_pkg::C_PIN_B_TX] ? s_q.tx_bit : s_q.ctrl[ssp_pkg::C_FLAG1];
			ser_oe[ssp_pkg::PIN_B] = 1'b1;
		end
		ser_o[ssp_pkg::PIN_FS]    = s_q.fs_int;
		ser_oe[ssp_pkg::PIN_FS]   = s_q.ctrl[ssp_pkg::C_FS_OUT];
		ser_o[ssp_pkg::PIN_SCK]   = s_q.bclk;
		ser_oe[ssp_pkg::PIN_SCK]  = s_q.ctrl[ssp_pkg::C_CLK_OUT];
		ser_oe[ssp_pkg::PIN_RXD]  = 1'b0;
		ser_o[ssp_pkg::PIN_TXD]   = s_q.tx_bit;
		ser_oe[ssp_pkg::PIN_TXD]  = s_q.ctrl[ssp_pkg::C_TX_EN];

		// pin drivers and port input; all held while stopped
		if (!stop_req) begin
			s_d.pin_o  = (s_q.pctl & ser_o) | (~s_q.pctl & s_q.pout);
			s_d.pin_oe = (s_q.pctl & ser_oe) | (~s_q.pctl & s_q.pdir);
			s_d.pin_in = pin_lvl;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q        <= '0;
			s_q.ctrl   <= ssp_pkg::CTRL_RST;
			s_q.div    <= ssp_pkg::DIV_RST;
			s_q.pctl   <= ssp_pkg::PORT_RST;
			s_q.pdir   <= ssp_pkg::PORT_RST;
			s_q.hready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs straight from flops
	// ------------------------------------------------------------
	assign hreadyout           = s_q.hready;
	assign hresp               = s_q.hresp;
	assign hrdata              = s_q.hrdata;
	assign ctrl_pin_a_o        = s_q.pin_o[ssp_pkg::PIN_A];
	assign ctrl_pin_a_oe       = s_q.pin_oe[ssp_pkg::PIN_A];
	assign ctrl_pin_b_o        = s_q.pin_o[ssp_pkg::PIN_B];
	assign ctrl_pin_b_oe       = s_q.pin_oe[ssp_pkg::PIN_B];
	assign frame_sync_pin_o    = s_q.pin_o[ssp_pkg::PIN_FS];
	assign frame_sync_pin_oe   = s_q.pin_oe[ssp_pkg::PIN_FS];
	assign serial_bit_clock_o  = s_q.pin_o[ssp_pkg::PIN_SCK];
	assign serial_bit_clock_oe = s_q.pin_oe[ssp_pkg::PIN_SCK];
	assign serial_rx_data_o    = s_q.pin_o[ssp_pkg::PIN_RXD];
	assign serial_rx_data_oe   = s_q.pin_oe[ssp_pkg::PIN_RXD];
	assign serial_tx_data_o    = s_q.pin_o[ssp_pkg::PIN_TXD];
	assign serial_tx_data_oe   = s_q.pin_oe[ssp_pkg::PIN_TXD];

endmodule : ssp_port

/* testbench/ssp_codec_model.sv */
`timescale 1ns/1ps
module ssp_codec_model #(
	parameter int W = 16
) (
	// pin levels seen
	input  wire logic         sck,
	input  wire logic         fs,
	input  wire logic         txd,
	// mode and word to send
	input  wire logic         ext,
	input  wire logic [W-1:0] pat,
	// pin drives
	output logic              sck_d,
	output logic              fs_d,
	output logic              rxd_d
);
	logic [W-1:0] got[$];
	logic [W-1:0] sh = '0;
	int           rcnt = 0;
	int           tcnt = W;

	initial begin
		sck_d = 1'b0;
		fs_d  = 1'b0;
		rxd_d = 1'b0;
	end

	// next receive bit after each rising clock, restart on frame sync
	always @(posedge sck) begin
		#1;
		if (!ext) begin
			if (fs) rcnt = 0;
			rxd_d = pat[W-1-(rcnt%W)];
			rcnt++;
		end
	end

	// capture transmit bits on falling clock, msb first
	always @(negedge sck) begin
		if (!ext && fs) tcnt = 0;
		if (!ext && tcnt < W) begin
			sh = {sh[W-2:0], txd};
			tcnt++;
			if (tcnt == W) got.push_back(sh);
		end
	end

	// one frame on an 80 ns clock, idle low outside the frame
	task automatic ext_frame(input logic [W-1:0] w);
		fs_d = 1'b1;
		#40;
		for (int i = W - 1; i >= 0; i--) begin
			sck_d = 1'b1;
			rxd_d = w[i];
			#40;
			sck_d = 1'b0;
			fs_d  = (i == W - 1); // sync spans the first fall for the receiver
			#39;
			sh = {sh[W-2:0], txd};
			#1;
		end
		got.push_back(sh);
		rxd_d = ~rxd_d;
	endtask : ext_frame
endmodule : ssp_codec_model

/* testbench/ssp_port_asserts.sv */
`timescale 1ns/1ps
module ssp_port_asserts (
	// clock, reset and bus inputs
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        stop_req,
	// pin drives and enables
	input wire logic        ctrl_pin_a_o,
	input wire logic        ctrl_pin_a_oe,
	input wire logic        ctrl_pin_b_o,
	input wire logic        ctrl_pin_b_oe,
	input wire logic        frame_sync_pin_o,
	input wire logic        frame_sync_pin_oe,
	input wire logic        serial_bit_clock_o,
	input wire logic        serial_bit_clock_oe,
	input wire logic        serial_rx_data_o,
	input wire logic        serial_rx_data_oe,
	input wire logic        serial_tx_data_o,
	input wire logic        serial_tx_data_oe
);
	logic [5:0] oe_v;
	logic [5:0] o_v;
	logic [5:0] pctl_q;
	logic       pctl_ph_q;
	logic       wr_seen_q;

	// pin vectors in port bit order
	assign oe_v = {serial_tx_data_oe, serial_rx_data_oe, serial_bit_clock_oe, frame_sync_pin_oe, ctrl_pin_b_oe,
		ctrl_pin_a_oe};
	assign o_v  = {serial_tx_data_o, serial_rx_data_o, serial_bit_clock_o, frame_sync_pin_o, ctrl_pin_b_o, ctrl_pin_a_o};

	// track first write and the pin function register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_seen_q <= 1'b0;
			pctl_ph_q <= 1'b0;
			pctl_q    <= 6'h00;
		end else begin
			if (hsel && htrans[1] && hready && hwrite) wr_seen_q <= 1'b1;
			pctl_ph_q <= hsel && htrans[1] && hready && hwrite && (haddr[7:0] == ssp_pkg::OFS_PCTL);
			if (pctl_ph_q) pctl_q <= hwdata[5:0];
		end
	end

	// ------------------------------------------------------------
	// pin properties
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_RST_OE: assert property (!wr_seen_q |-> oe_v == 6'h00)
		else $error("pin enabled before any register write");
	AST_RST_OUT: assert property (!wr_seen_q |-> o_v == 6'h00)
		else $error("pin level set before any register write");
	AST_STOP_OE: assert property ($past(stop_req) |-> $stable(oe_v))
		else $error("pin enable moved in stop state");
	AST_STOP_OUT: assert property ($past(stop_req) |-> $stable(o_v))
		else $error("pin level moved in stop state");
	AST_RXD_IN: assert property (pctl_q[4] && $past(pctl_q[4], 2) |-> !serial_rx_data_oe)
		else $error("receive data pin driven in serial function");
	AST_SCK_HIGH: assert property (pctl_q[3] && serial_bit_clock_oe && $rose(serial_bit_clock_o)
		|=> (serial_bit_clock_o || !serial_bit_clock_oe) [*2]) else $error("bit clock high phase too short");
	AST_SCK_LOW: assert property (pctl_q[3] && serial_bit_clock_oe && $fell(serial_bit_clock_o)
		|=> (!serial_bit_clock_o || !serial_bit_clock_oe) [*2]) else $error("bit clock low phase too short");
	AST_FS_BIT: assert property (pctl_q[2] && frame_sync_pin_oe && $rose(frame_sync_pin_o)
		|=> (frame_sync_pin_o || !frame_sync_pin_oe) [*5]) else $error("frame sync shorter than a bit");
endmodule : ssp_port_asserts

bind ssp_port ssp_port_asserts i_ssp_port_asserts (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .stop_req,
	.ctrl_pin_a_o, .ctrl_pin_a_oe, .ctrl_pin_b_o, .ctrl_pin_b_oe, .frame_sync_pin_o, .frame_sync_pin_oe,
	.serial_bit_clock_o, .serial_bit_clock_oe, .serial_rx_data_o, .serial_rx_data_oe,
	.serial_tx_data_o, .serial_tx_data_oe
);

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        stop_req = 1'b0;
	logic        ser = 1'b0;
	logic        ext = 1'b0;
	logic [5:0]  gp_q = 6'h0;
	logic [15:0] pat = 16'h0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [5:0]  ov;
	logic [5:0]  dv;
	logic [5:0]  pv;
	logic [5:0]  pin;
	logic        sck_d;
	logic        fs_d;
	logic        rxd_d;
	logic [31:0] seed = 32'he6b20ef4;
	int          fails = 0;
	int          comparisons = 0;
	logic [15:0] exp[$];
	logic [7:0]  ra[5] = '{ssp_pkg::OFS_CTRL, ssp_pkg::OFS_DIV, ssp_pkg::OFS_PCTL, ssp_pkg::OFS_PDIR, 8'h24};
	logic [31:0] rv[5] = '{{21'h0, ssp_pkg::CTRL_RST}, {24'h0, ssp_pkg::DIV_RST}, 32'h0, 32'h0, 32'h0};

	always #5 hclk = ~hclk;

	// wire levels: port drive where its enable is set, far-side level elsewhere
	assign pv  = {gp_q[5], ser ? rxd_d : gp_q[4], ext ? sck_d : gp_q[3], ext ? fs_d : gp_q[2], gp_q[1:0]};
	assign pin = (ov & dv) | (~ov & pv);

	ssp_port i_ssp_port (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .stop_req(stop_req),
		.ctrl_pin_a_i(pin[0]), .ctrl_pin_a_o(dv[0]), .ctrl_pin_a_oe(ov[0]),
		.ctrl_pin_b_i(pin[1]), .ctrl_pin_b_o(dv[1]), .ctrl_pin_b_oe(ov[1]),
		.frame_sync_pin_i(pin[2]), .frame_sync_pin_o(dv[2]), .frame_sync_pin_oe(ov[2]),
		.serial_bit_clock_i(pin[3]), .serial_bit_clock_o(dv[3]), .serial_bit_clock_oe(ov[3]),
		.serial_rx_data_i(pin[4]), .serial_rx_data_o(dv[4]), .serial_rx_data_oe(ov[4]),
		.serial_tx_data_i(pin[5]), .serial_tx_data_o(dv[5]), .serial_tx_data_oe(ov[5])
	);

	ssp_codec_model #(.W(16)) i_ssp_codec_model (
		.sck(pin[3]), .fs(pin[2]), .txd(pin[5]), .ext(ext), .pat(pat),
		.sck_d(sck_d), .fs_d(fs_d), .rxd_d(rxd_d)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic int nz();
		int c;
		c = 0;
		foreach (i_ssp_codec_model.got[i]) if (i_ssp_codec_model.got[i] != 16'h0) c++;
		return c;
	endfunction : nz

	// one single transfer, entered just after a rising edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, want, seen);
		end
	endtask : chk

	task automatic give_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : give_verdict

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [31:0] w;
		int          j;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b1, 8'h24, xs());
		for (int k = 0; k < 5; k++) begin
			ahb(1'b0, ra[k], 32'h0);
			chk("reset value", rd, rv[k]);
		end
		// port pins as outputs, then frozen by the stop state
		r = xs();
		ahb(1'b1, ssp_pkg::OFS_PDIR, 32'h3f);
		ahb(1'b1, ssp_pkg::OFS_POUT, r);
		repeat (3) @(posedge hclk);
		chk("pin drive", {20'h0, ov, dv}, {20'h0, 6'h3f, r[5:0]});
		stop_req <= 1'b1;
		ahb(1'b1, ssp_pkg::OFS_POUT, ~r);
		repeat (3) @(posedge hclk);
		chk("stop hold", {26'h0, dv}, {26'h0, r[5:0]});
		stop_req <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("stop release", {26'h0, dv}, {26'h0, ~r[5:0]});
		// port pins as inputs
		ahb(1'b1, ssp_pkg::OFS_PDIR, 32'h0);
		gp_q <= r[11:6];
		repeat (4) @(posedge hclk);
		ahb(1'b0, ssp_pkg::OFS_PIN, 32'h0);
		chk("pin level", rd, {26'h0, r[11:6]});
		// internal clock and frame sync, flags on the control pins
		r = xs();
		pat <= r[15:0];
		ser <= 1'b1;
		gp_q <= 6'h0;
		ahb(1'b1, ssp_pkg::OFS_DIV, 32'h8);
		ahb(1'b1, ssp_pkg::OFS_PCTL, 32'h3f);
		ahb(1'b1, ssp_pkg::OFS_CTRL, 32'h21b);
		repeat (1000) @(posedge hclk);
		chk("flag pins", {28'h0, ov[1:0], dv[1:0]}, 32'hd);
		ahb(1'b0, ssp_pkg::OFS_STATUS, 32'h0);
		chk("status", {28'h0, rd[3:0]}, 32'hf);
		// transmitter paused so no frame start drains the buffer mid-loop
		ahb(1'b1, ssp_pkg::OFS_CTRL, 32'h21a);
		for (int k = 0; k < 4; k++) begin
			ahb(1'b0, ssp_pkg::OFS_STATUS, 32'h0);
			w = xs() | 32'h1;
			if (rd[0]) exp.push_back(w[15:0]);
			ahb(1'b1, ssp_pkg::OFS_TXDATA, w);
		end
		ahb(1'b1, ssp_pkg::OFS_CTRL, 32'h21b);
		chk("tx refusal", 32'(exp.size()), 32'h2);
		for (j = 0; j < 3000 && nz() < exp.size(); j++) @(posedge hclk);
		j = 0;
		foreach (i_ssp_codec_model.got[i]) if (i_ssp_codec_model.got[i] != 16'h0 && j < exp.size()) begin
			chk("tx word", {16'h0, i_ssp_codec_model.got[i]}, {16'h0, exp[j]});
			j++;
		end
		chk("tx count", 32'(j), 32'(exp.size()));
		for (int k = 0; k < 2; k++) begin
			ahb(1'b0, ssp_pkg::OFS_RXDATA, 32'h0);
			chk("rx word", rd, {16'h0, pat});
		end
		// external bit clock and frame sync from the far side, entered with both sides stopped
		ahb(1'b1, ssp_pkg::OFS_CTRL, 32'h0);
		ext  <= 1'b1;
		for (int k = 0; k < 3; k++) ahb(1'b0, ssp_pkg::OFS_RXDATA, 32'h0);
		ahb(1'b1, ssp_pkg::OFS_CTRL, 32'h3);
		i_ssp_codec_model.got.delete();
		r = xs();
		ahb(1'b1, ssp_pkg::OFS_TXDATA, r);
		#3;
		i_ssp_codec_model.ext_frame(r[31:16]);
		repeat (10) @(posedge hclk);
		chk("ext tx word", {16'h0, i_ssp_codec_model.got[0]}, {16'h0, r[15:0]});
		ahb(1'b0, ssp_pkg::OFS_RXDATA, 32'h0);
		chk("ext rx word", rd, {16'h0, r[31:16]});
		// asynchronous mode: pin a drives the receive clock, pin b takes frame sync in
		ahb(1'b1, ssp_pkg::OFS_CTRL, 32'h24);
		repeat (3) @(posedge hclk);
		chk("async pins", {30'h0, ov[1:0]}, 32'h1);
		chk("response", {31'h0, hresp}, 32'h0);
		give_verdict();
	end
endmodule : tb
